// [corrected_block_output_scheduler.sv]
/*
  Schedules release of row- and frame-corrected blocks to the host.
  Assumes decoder strobes on i_clock; host pins arrive asynchronously.
*/
`timescale 1ns/1ns
`include "corrected_block_output_scheduler_params.svh"

module corrected_block_output_scheduler
  import corrected_block_output_scheduler_pkg::*;
#(
  parameter int P_WIN_CYC = `WIN_CYC,
  parameter int P_ROW_WIN_CYC = `ROW_WIN_CYC,
  parameter int P_READY_CYC = `READY_CYC,
  parameter int P_MARGIN_CYC = `MARGIN_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Mode strap level
  input wire logic i_serial_mode,
  // Decoder events, same clock
  input wire logic i_bic_det,
  input wire logic i_frame_start,
  input wire logic i_frame_sync,
  input wire logic i_row_done,
  input wire logic i_row_ok,
  input wire logic i_row_parity,
  input wire logic [7:0] i_row_num,
  input wire logic i_col_done,
  // Host pins, asynchronous
  input wire logic i_host_read,
  input wire logic i_skip_wr,
  input wire logic [7:0] i_skip_num,
  // Outputs
  output logic o_accept,
  output logic o_block_start_strobe,
  output logic o_col_start,
  output logic o_buf_wr,
  output logic o_buf_valid,
  output logic o_irq_n,
  output logic o_ready_n,
  output status_s o_status
);

  // ==========================================================
  // Host pin synchronisers
  logic [2:0] rd_sync_r;
  logic [2:0] skw_sync_r;
  logic [7:0] skn_s1_r;
  logic [7:0] skn_s2_r;
  // Strap is a pin too; reset level is serial, its pulled-up default
  logic [1:0] ser_sync_r;
  wire logic host_rd_edge = rd_sync_r[1] & ~rd_sync_r[2];
  wire logic skip_edge = skw_sync_r[1] & ~skw_sync_r[2];

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      rd_sync_r <= 3'h0;
      skw_sync_r <= 3'h0;
      skn_s1_r <= 8'h00;
      skn_s2_r <= 8'h00;
      ser_sync_r <= 2'h3;
    end else begin
      rd_sync_r <= {rd_sync_r[1:0], i_host_read};
      skw_sync_r <= {skw_sync_r[1:0], i_skip_wr};
      skn_s1_r <= i_skip_num;
      skn_s2_r <= skn_s1_r;
      ser_sync_r <= {ser_sync_r[0], i_serial_mode};
    end
  end

  // ==========================================================
  // Frame tracking and frame correction launch
  logic [8:0] rx_idx_r;
  logic [8:0] stored_r;
  logic all_ok_r;
  logic vert_en_r;
  logic col_ran_r;
  logic col_fin_r;
  logic accept_r;
  logic strobe_r;
  logic col_start_r;
  // Sync loss abandons the frame output; no half-corrected frames
  wire logic prev_full = (stored_r == `BLOCKS_PER_FRAME);
  wire logic col_need = prev_full & i_frame_sync & ~all_ok_r;
  wire logic [8:0] rx_idx_inc = rx_idx_r + 9'h001;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      accept_r <= 1'b0;
      strobe_r <= 1'b0;
      col_start_r <= 1'b0;
      rx_idx_r <= 9'h000;
      stored_r <= 9'h000;
      all_ok_r <= 1'b1;
      vert_en_r <= 1'b0;
      col_ran_r <= 1'b0;
      col_fin_r <= 1'b0;
    end else begin
      accept_r <= 1'b1;
      strobe_r <= i_bic_det;
      col_start_r <= i_frame_start & col_need;
      if (i_frame_start) begin
        rx_idx_r <= 9'h000;
        stored_r <= 9'h000;
        all_ok_r <= 1'b1;
        vert_en_r <= prev_full & i_frame_sync;
        col_ran_r <= col_need;
        col_fin_r <= 1'b0;
      end else begin
        if (i_bic_det) begin
          rx_idx_r <= rx_idx_inc;
        end
        if (i_row_done && stored_r != `BLOCKS_PER_FRAME) begin
          stored_r <= stored_r + 9'h001;
        end
        if (i_row_done && !i_row_ok) begin
          all_ok_r <= 1'b0;
        end
        if (!i_frame_sync) begin
          vert_en_r <= 1'b0;
        end
        if (i_col_done) begin
          col_fin_r <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Pending requests: row result and frame slot
  sched_e st_r;
  logic row_pend_r;
  logic frm_pend_r;
  logic skip_pend_r;
  logic [7:0] skip_num_r;
  logic [7:0] vnum_r;
  status_s row_stat_r;
  wire logic idle = (st_r == ST_IDLE);
  wire logic take_row = idle & row_pend_r;
  wire logic take_frm = idle & ~row_pend_r & frm_pend_r;
  // Slot opens on identifier of block 29 onward, while data remains
  wire logic frm_slot = i_bic_det & vert_en_r & ~i_frame_start
    & (rx_idx_inc >= `FIRST_VERT_SLOT) & (vnum_r < `DATA_BLOCKS);
  wire logic [7:0] frm_num = skip_pend_r ? skip_num_r : vnum_r;
  wire logic row_pend_nxt = i_row_done | (row_pend_r & ~take_row);
  wire logic frm_pend_nxt = frm_slot | (frm_pend_r & ~take_frm);
  // A skip landing with the take is kept for the next slot
  wire logic skip_pend_nxt = skip_edge | (skip_pend_r & ~take_frm);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      row_pend_r <= 1'b0;
      frm_pend_r <= 1'b0;
      skip_pend_r <= 1'b0;
      skip_num_r <= 8'h00;
      row_stat_r <= '0;
    end else begin
      row_pend_r <= row_pend_nxt;
      frm_pend_r <= frm_pend_nxt & ~i_frame_start;
      skip_pend_r <= skip_pend_nxt;
      if (skip_edge) begin
        skip_num_r <= skn_s2_r;
      end
      if (i_row_done) begin
        row_stat_r <= '{frame_out: 1'b0, parity: i_row_parity, corrected: i_row_ok,
          spare: 5'h00, block_number_field: i_row_num};
      end
    end
  end

  // Frame block numbering restarts each frame
  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_frame_start) begin
      vnum_r <= 8'h00;
    end else if (take_frm) begin
      vnum_r <= frm_num + 8'h01;
    end
  end

  // ==========================================================
  // Output scheduler: buffer write, then read window
  logic [19:0] cnt_r;
  logic [19:0] win_lim_r;
  logic buf_wr_r;
  logic buf_valid_r;
  logic irq_n_r;
  logic ready_n_r;
  status_s stat_r;
  sched_e st_nxt;
  // Row-only frames give the long window; shared slots halve it
  wire logic share = vert_en_r & (vnum_r < `DATA_BLOCKS);
  wire logic [19:0] lim_sel = (take_frm | share) ? 20'(P_WIN_CYC - 1)
    : 20'(P_ROW_WIN_CYC - 1);
  wire logic wr_end = (st_r == ST_WRITE) & (cnt_r == 20'(`WRITE_CYC - 1));
  wire logic win_end = (st_r == ST_WINDOW) & (cnt_r == win_lim_r);
  wire logic rdy_end = (st_r == ST_WINDOW) & (cnt_r == 20'(P_READY_CYC - 1));
  // Uncorrected frames fall back to row content in the frame slot
  wire logic frm_corr = col_ran_r & col_fin_r;
  wire status_s frm_stat = '{frame_out: 1'b1, parity: 1'b0, corrected: frm_corr,
    spare: 5'h00, block_number_field: frm_num};

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (take_row || take_frm) begin
          st_nxt = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (wr_end) begin
          st_nxt = ST_WINDOW;
        end
      end
      ST_WINDOW: begin
        if (win_end) begin
          st_nxt = ST_IDLE;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 20'h00000;
      win_lim_r <= 20'h00000;
      stat_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 20'h00000 : cnt_r + 20'h00001;
      if (take_row || take_frm) begin
        win_lim_r <= lim_sel;
        stat_r <= take_row ? row_stat_r : frm_stat;
      end
    end
  end

  // Pin levels; parallel mode leaves the ready line high
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      buf_wr_r <= 1'b0;
      buf_valid_r <= 1'b0;
      irq_n_r <= 1'b1;
      ready_n_r <= 1'b1;
    end else begin
      buf_wr_r <= (st_nxt == ST_WRITE);
      buf_valid_r <= (st_nxt == ST_WINDOW);
      if (wr_end) begin
        irq_n_r <= 1'b0;
        ready_n_r <= ~ser_sync_r[1];
      end else begin
        if (host_rd_edge || win_end) begin
          irq_n_r <= 1'b1;
        end
        if (rdy_end || win_end) begin
          ready_n_r <= 1'b1;
        end
      end
    end
  end

  assign o_accept = accept_r;
  assign o_block_start_strobe = strobe_r;
  assign o_col_start = col_start_r;
  assign o_buf_wr = buf_wr_r;
  assign o_buf_valid = buf_valid_r;
  assign o_irq_n = irq_n_r;
  assign o_ready_n = ready_n_r;
  assign o_status = stat_r;

  // ==========================================================
  // Checks
  chk_accept_after_reset: assert property (@(posedge i_clock)
    (!i_rst_n ##1 i_rst_n) |-> !o_accept ##1 o_accept)
    else $error("accept not one cycle after reset");

  chk_strobe_after_id: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    i_bic_det |=> o_block_start_strobe)
    else $error("block start strobe missing after identifier");

  chk_ready_with_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_ready_n) |-> $fell(o_irq_n))
    else $error("ready line fell without interrupt");

  chk_write_before_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $fell(o_irq_n) |-> $past(o_buf_wr) && $past(cnt_r) == 20'(`WRITE_CYC - 1))
    else $error("interrupt without full buffer write");

  chk_ready_margin: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (!o_ready_n && st_r == ST_WINDOW) |-> (win_lim_r - cnt_r) >= 20'(P_MARGIN_CYC - 1))
    else $error("ready low with under 3 ms left");

  chk_one_block_irq: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_irq_n |-> !o_buf_wr && o_buf_valid)
    else $error("buffer rewritten during interrupt");

  chk_frame_no_parity: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_status.frame_out |-> !o_status.parity && o_status.block_number_field < `DATA_BLOCKS)
    else $error("parity or bad number in frame output");

  chk_col_start_cond: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_col_start |-> $past(prev_full && i_frame_sync && !all_ok_r && i_frame_start))
    else $error("frame correction started wrongly");

  chk_frame_slot_late: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    frm_slot |-> rx_idx_r >= 9'h01C)
    else $error("frame slot before block 29");

  chk_skip_apply: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (take_frm && skip_pend_r) |=> o_status.block_number_field == $past(skip_num_r))
    else $error("skip target not applied");

  cov_frame_out: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    take_frm ##1 o_buf_wr);
  cov_skip_used: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    take_frm && skip_pend_r);
  cov_host_release: cover property (@(posedge i_clock) disable iff (!i_rst_n)
    !o_irq_n && host_rd_edge);

endmodule

// [corrected_block_output_scheduler_params.svh]
/*
  Constants of the corrected block output scheduler: frame geometry and timing.
  Assumes a 50 MHz core clock; cycle counts derive from the time figures.
*/
`ifndef CORRECTED_BLOCK_OUTPUT_SCHEDULER_PARAMS_SVH
`define CORRECTED_BLOCK_OUTPUT_SCHEDULER_PARAMS_SVH

// ==========================================================
// Clock
`define CLK_MHZ 50

// ==========================================================
// Frame geometry
`define BLOCKS_PER_FRAME 9'h110
`define DATA_BLOCKS 8'hBE
`define FIRST_VERT_SLOT 9'h01D
`define BLOCK_BITS 288
`define STATUS_BITS 16

// ==========================================================
// Timing, figures in their own units
`define T_WIN_MS 9
`define T_ROW_WIN_MS 18
`define T_READY_MS 6
`define T_MARGIN_MS 3
`define T_WRITE_US 68

// Derived cycle counts
`define WIN_CYC (`T_WIN_MS * 1000 * `CLK_MHZ)
`define ROW_WIN_CYC (`T_ROW_WIN_MS * 1000 * `CLK_MHZ)
`define READY_CYC (`T_READY_MS * 1000 * `CLK_MHZ)
`define MARGIN_CYC (`T_MARGIN_MS * 1000 * `CLK_MHZ)
`define WRITE_CYC (`T_WRITE_US * `CLK_MHZ)

`endif

// [corrected_block_output_scheduler_pkg.sv]
/*
  Types of the corrected block output scheduler.
  Assumes the params header supplies all numeric constants.
*/
package corrected_block_output_scheduler_pkg;

  // ==========================================================
  // Output scheduler states, Gray along idle-write-window
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WRITE = 2'b01,
    ST_WINDOW = 2'b11
  } sched_e;

  // ==========================================================
  // Two status bytes leading each delivered block
  typedef struct packed {
    logic frame_out;
    logic parity;
    logic corrected;
    logic [4:0] spare;
    logic [7:0] block_number_field;
  } status_s;

endpackage

// [corrected_block_output_scheduler_tb.sv]
/*
  Self-checking bench of the corrected block output scheduler.
  Assumes shortened window parameters and a host model on the pins.
*/
`timescale 1ns/1ns
module corrected_block_output_scheduler_tb;
  import corrected_block_output_scheduler_pkg::*;
  // ==========================================================
  // Signals
  logic clk = 0, rst_n = 0, block_identifier_code = 0, fst = 0, rdone = 0, rok = 0, rpar = 0;
  logic cdone = 0, skw = 0, slow = 1, hread, acc, bst, cst, bwr, bval, irq_n, rdy_n;
  logic fsync = 1, smode = 1;
  logic [7:0] rnum = 8'h00, sknum = 8'h00;
  status_s st;
  int mismatches = 0, checks = 0, n;
  always #10 clk = ~clk;
  corrected_block_output_scheduler #(.P_WIN_CYC(9000), .P_ROW_WIN_CYC(18000),
    .P_READY_CYC(6000), .P_MARGIN_CYC(3000)) u_dut (.i_clock(clk), .i_rst_n(rst_n),
    .i_serial_mode(smode), .i_bic_det(block_identifier_code), .i_frame_start(fst), .i_frame_sync(fsync),
    .i_row_done(rdone), .i_row_ok(rok), .i_row_parity(rpar), .i_row_num(rnum),
    .i_col_done(cdone), .i_host_read(hread), .i_skip_wr(skw), .i_skip_num(sknum),
    .o_accept(acc), .o_block_start_strobe(bst), .o_col_start(cst), .o_buf_wr(bwr),
    .o_buf_valid(bval), .o_irq_n(irq_n), .o_ready_n(rdy_n), .o_status(st));
  host_cpu_model u_host (.i_clock(clk), .i_slow(slow), .i_irq_n(irq_n),
    .o_host_read(hread));
  // ==========================================================
  // Shared tasks
  task automatic wrap_up;
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge clk);
      #1;
    end
  endtask
  function automatic logic cur(input int sel);
    case (sel)
      0: return bwr;
      1: return irq_n;
      2: return rdy_n;
      default: return bval;
    endcase
  endfunction
  // Bounded wait; the count gives the cycles spent
  task automatic wt(input int sel, input logic lvl, input int bound, output int k);
    k = 0;
    while (cur(sel) !== lvl && k < bound) begin
      tick(1);
      k++;
    end
    if (k >= bound) begin
      mismatches++;
      $display("MISMATCH wait_%0d expected %b seen timeout", sel, lvl);
      wrap_up;
    end
  endtask
  task automatic pulse_bic;
    block_identifier_code = 1;
    tick(1);
    check("strobe", bst, 1);
    block_identifier_code = 0;
    tick(1);
  endtask
  // ==========================================================
  // Scenarios
  task automatic sc_reset;
    tick(10);
    check("irq_rst", irq_n, 1);
    check("rdy_rst", rdy_n, 1);
    rst_n = 1;
    tick(1);
    check("accept", acc, 1);
  endtask
  // First row block timed by a slow host, frame memory filled meanwhile
  task automatic sc_row_fill;
    rnum = 8'h00;
    rpar = 1;
    rok = 1;
    rdone = 1;
    wt(0, 1, 5, n);
    check("row_par", st.parity, 1);
    check("row_num", st.block_number_field, 8'h00);
    check("row_fout", st.frame_out, 0);
    for (int k = 1; k < 272; k++) begin
      rnum = k[7:0];
      rpar = 0;
      rok = (k != 5);
      tick(1);
    end
    rdone = 0;
    wt(1, 0, 4000, n);
    check("write_len", 16'(n + 271), 16'(3400));
    check("rdy_low", rdy_n, 0);
    check("valid", bval, 1);
    wt(2, 1, 7000, n);
    check("rdy_len", 16'(n), 16'(6000));
    wt(3, 0, 13000, n);
    check("win_len", 16'(n), 16'(12000));
    check("irq_end", irq_n, 1);
  endtask
  // Pending last row answered by a prompt host
  task automatic sc_host_read;
    slow = 0;
    wt(0, 1, 5, n);
    check("last_num", st.block_number_field, 8'h0F);
    wt(1, 0, 4000, n);
    wt(1, 1, 200, n);
    check("irq_read", irq_n, 1);
    wt(3, 0, 20000, n);
  endtask
  // Frame correction, slot timing and skip
  task automatic sc_frame;
    fst = 1;
    tick(1);
    fst = 0;
    check("col_start", cst, 1);
    cdone = 1;
    tick(1);
    cdone = 0;
    for (int k = 0; k < 28; k++) begin
      pulse_bic;
    end
    check("no_slot", bwr, 0);
    pulse_bic;
    wt(0, 1, 5, n);
    check("f_out", st.frame_out, 1);
    check("f_num", st.block_number_field, 8'h00);
    check("f_par", st.parity, 0);
    check("f_corr", st.corrected, 1);
    sknum = 8'h05;
    tick(2);
    skw = 1;
    tick(5);
    skw = 0;
    wt(3, 1, 4000, n);
    wt(3, 0, 10000, n);
    check("fwin_len", 16'(n), 16'(9000));
    pulse_bic;
    wt(0, 1, 5, n);
    check("skip_num", st.block_number_field, 8'h05);
    // Parallel strap and sync loss while this block is written
    fsync = 0;
    smode = 0;
    wt(1, 0, 4000, n);
    check("par_rdy", rdy_n, 1);
    wt(3, 0, 10000, n);
    pulse_bic;
    tick(2);
    check("sync_lost", bwr, 0);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    sc_reset;
    sc_row_fill;
    sc_host_read;
    sc_frame;
    wrap_up;
  end
endmodule

// [host_cpu_model.sv]
/*
  Host CPU model: unless i_slow is set, answers each interrupt fall by pulsing its read pin.
  Assumes the scheduler's active-low interrupt, sampled on the same clock.
*/
`timescale 1ns/1ns
module host_cpu_model (
  // Clock and control
  input wire logic i_clock,
  input wire logic i_slow,
  // Scheduler side
  input wire logic i_irq_n,
  output logic o_host_read
);
  // ==========================================================
  // Edge-triggered response
  logic irq_q = 1'b1;
  initial o_host_read = 1'b0;
  // Slow host never reads, so the window must close on its own
  always @(posedge i_clock) begin
    irq_q <= i_irq_n;
    if (irq_q && !i_irq_n && !i_slow) begin
      repeat (20) @(posedge i_clock);
      #1 o_host_read = 1'b1;
      repeat (100) @(posedge i_clock);
      #1 o_host_read = 1'b0;
    end
  end
endmodule
